// ===== hdl/vcp_top.sv
// valve current pwm control: apb registers, source select, pi current loop
//
// Summary of operation
// - With closed loop selected the driver duty comes from the current regulator.
// - With closed loop deselected the driver duty is exactly the script duty value.
// - With lower source selected the lowering command is the throttle position.
// - With lower source deselected the lowering command is the script lower value.
// - The undithered setpoint never exceeds the ceiling current, which saturates at raw 607.
// - While the floor is at or below the ceiling, the undithered setpoint never falls below the floor current on the same raw scale.
// - Dither alternately adds and subtracts a percentage of the ceiling current.
// - The dither period is 16 ms times the period code 1 to 7.
// - The error is scaled by a proportional gain, raw 82 to 8192.
// - The error is integrated with an integral gain, raw 327 to 32767.
// - Limits, dither and gains act only while closed loop is selected.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module vcp_top #(
   parameter int TICK_CYC = vcp_pkg::TICK_CYC
) (
   input  wire logic               clk_sys,      // 100 MHz clock
   input  wire logic               rstn,         // async reset, active low
   input  wire logic               psel,         // apb select
   input  wire logic               penable,      // apb access phase
   input  wire logic               pwrite,       // apb write
   input  wire logic [11:0]        paddr,        // apb byte address
   input  wire logic [31:0]        pwdata,       // apb write data
   output logic                    pready,       // apb ready
   output logic      [31:0]        prdata,       // apb read data
   output logic                    pslverr,      // apb error, unmapped
   input  wire logic [14:0]        throttle_pos, // throttle position 0..32767
   input  wire logic [9:0]         coil_current, // measured coil current raw
   output logic                    valve_driver_channel, // driver pwm pin
   output logic      [14:0]        drive_duty    // duty now applied
);
   logic [1:0]              ctrl_r;
   logic [9:0]              coil_current_ceiling_r;
   logic [9:0]              coil_current_floor_r;
   logic [14:0]             dither_amplitude_pct_r;
   logic [2:0]              dither_period_code_r;
   logic [13:0]             proportional_gain_r;
   logic [14:0]             integral_gain_r;
   logic [14:0]             script_duty_r;
   logic [14:0]             script_lower_command_r;
   logic [16:0]             tick_cnt_r;
   logic                    tick_r;
   logic signed [19:0]      integ_r;
   logic [11:0]             sp_r;
   logic                    closed_loop_select;
   logic                    lower_source_select;
   logic                    wr_en;
   logic                    rd_en;
   logic [14:0]             lower_cmd;
   logic [9:0]              floor_eff;
   logic [9:0]              span;
   logic [24:0]             span_prod;
   logic [9:0]              base_sp;
   logic signed [11:0]      dith_off;
   logic signed [12:0]      dith_sum;
   logic [11:0]             sp_dith;
   logic signed [12:0]      err;
   logic signed [28:0]      p_prod;
   logic signed [28:0]      i_prod;
   logic signed [20:0]      p_term;
   logic signed [20:0]      i_inc;
   logic signed [21:0]      pi_sum;
   logic signed [21:0]      integ_nxt;
   logic                    sat_hi;
   logic                    sat_lo;
   logic [31:0]             rd_mux;
   logic                    rd_hit;

   // clamp a signed value to the legal duty range
   function automatic logic [14:0] sat15(input logic signed [21:0] v);
      if (v < 0) return 15'h0000;
      if (v > $signed({7'h00, vcp_pkg::DUTY_MAX})) return vcp_pkg::DUTY_MAX;
      return v[14:0];
   endfunction : sat15

   // current settings beyond 2.0 A, or with any upper bit set, saturate at the top raw value
   function automatic logic [9:0] sat_cur(input logic [31:0] v);
      if (v[31:10] != 22'h00_0000 || v[9:0] > vcp_pkg::CUR_RAW_MAX) return vcp_pkg::CUR_RAW_MAX;
      return v[9:0];
   endfunction : sat_cur

   assign closed_loop_select  = ctrl_r[vcp_pkg::CTRL_CL_BIT];
   assign lower_source_select = ctrl_r[vcp_pkg::CTRL_LS_BIT];

   // one wait state: pready rises the cycle after the access phase begins
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_en;
         if (rd_en) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !rd_hit;
         end
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      case (paddr)
         vcp_pkg::OFS_CTRL:   rd_mux = {30'h0, ctrl_r};
         vcp_pkg::OFS_CEIL:   rd_mux = {22'h0, coil_current_ceiling_r};
         vcp_pkg::OFS_FLOOR:  rd_mux = {22'h0, coil_current_floor_r};
         vcp_pkg::OFS_DPCT:   rd_mux = {17'h0, dither_amplitude_pct_r};
         vcp_pkg::OFS_DPER:   rd_mux = {29'h0, dither_period_code_r};
         vcp_pkg::OFS_KP:     rd_mux = {18'h0, proportional_gain_r};
         vcp_pkg::OFS_KI:     rd_mux = {17'h0, integral_gain_r};
         vcp_pkg::OFS_SDUTY:  rd_mux = {17'h0, script_duty_r};
         vcp_pkg::OFS_SLOWER: rd_mux = {17'h0, script_lower_command_r};
         vcp_pkg::OFS_STDUTY: rd_mux = {17'h0, drive_duty};
         vcp_pkg::OFS_STSP:   rd_mux = {20'h0, sp_r};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_r                 <= vcp_pkg::CTRL_RST;
         coil_current_ceiling_r <= vcp_pkg::CEIL_RST;
         coil_current_floor_r   <= vcp_pkg::FLOOR_RST;
         dither_amplitude_pct_r <= vcp_pkg::DPCT_RST;
         dither_period_code_r   <= vcp_pkg::DPER_RST;
         proportional_gain_r    <= vcp_pkg::KP_RST;
         integral_gain_r        <= vcp_pkg::KI_RST;
         script_duty_r          <= 15'h0000;
         script_lower_command_r <= 15'h0000;
      end else if (wr_en) begin
         case (paddr)
            vcp_pkg::OFS_CTRL:   ctrl_r <= pwdata[1:0];
            vcp_pkg::OFS_CEIL:   coil_current_ceiling_r <= sat_cur(pwdata);
            vcp_pkg::OFS_FLOOR:  coil_current_floor_r <= sat_cur(pwdata);
            vcp_pkg::OFS_DPCT:   dither_amplitude_pct_r <= pwdata[14:0];
            vcp_pkg::OFS_DPER:   dither_period_code_r <= pwdata[2:0];
            vcp_pkg::OFS_KP:     proportional_gain_r <= pwdata[13:0];
            vcp_pkg::OFS_KI:     integral_gain_r <= pwdata[14:0];
            vcp_pkg::OFS_SDUTY:  script_duty_r <= pwdata[14:0];
            vcp_pkg::OFS_SLOWER: script_lower_command_r <= pwdata[14:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == 17'(TICK_CYC - 1));
         if (tick_cnt_r == 17'(TICK_CYC - 1)) tick_cnt_r <= '0;
         else tick_cnt_r <= tick_cnt_r + 17'h0_0001;
      end
   end

   vcp_dither u_dither (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tick    (tick_r),
      .run     (closed_loop_select),
      .code    (dither_period_code_r),
      .ceil    (coil_current_ceiling_r),
      .pct     (dither_amplitude_pct_r),
      .offset  (dith_off)
   );

   always_comb begin
      lower_cmd = lower_source_select ? throttle_pos : script_lower_command_r;
      // a floor above the ceiling is pulled down so the ceiling still holds
      floor_eff = (coil_current_floor_r > coil_current_ceiling_r) ?
                  coil_current_ceiling_r : coil_current_floor_r;
      span      = coil_current_ceiling_r - floor_eff;
      span_prod = span * lower_cmd;
      base_sp   = floor_eff + span_prod[24:vcp_pkg::PCT_SHIFT];
      dith_sum  = $signed({3'b000, base_sp}) + 13'(dith_off);
      sp_dith   = (dith_sum < 0) ? 12'h000 : dith_sum[11:0];
      err       = $signed({1'b0, sp_dith}) - $signed({3'b000, coil_current});
      p_prod    = err * $signed({1'b0, proportional_gain_r});
      i_prod    = err * $signed({1'b0, integral_gain_r});
      p_term    = 21'(p_prod >>> vcp_pkg::KP_SHIFT);
      i_inc     = 21'(i_prod >>> vcp_pkg::KI_SHIFT);
      pi_sum    = 22'(p_term) + 22'(integ_r);
      sat_hi    = pi_sum > $signed({7'h00, vcp_pkg::DUTY_MAX});
      sat_lo    = pi_sum < 0;
      integ_nxt = 22'(integ_r) + 22'(i_inc);
   end

   // integrator and setpoint advance on the control tick only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         integ_r <= '0;
         sp_r    <= '0;
      end else if (!closed_loop_select) begin
         integ_r <= '0;
         sp_r    <= '0;
      end else if (tick_r) begin
         sp_r <= sp_dith;
         // freeze the integrator while the output is pinned in the error's direction
         if (!((sat_hi && err > 0) || (sat_lo && err < 0))) begin
            if (integ_nxt > $signed({7'h00, vcp_pkg::DUTY_MAX}))
               integ_r <= 20'($signed({7'h00, vcp_pkg::DUTY_MAX}));
            else if (integ_nxt < -$signed({7'h00, vcp_pkg::DUTY_MAX}))
               integ_r <= 20'(-$signed({7'h00, vcp_pkg::DUTY_MAX}));
            else
               integ_r <= 20'(integ_nxt);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         drive_duty <= 15'h0000;
      end else if (!closed_loop_select) begin
         drive_duty <= script_duty_r;
      end else if (tick_r) begin
         drive_duty <= sat15(pi_sum);
      end
   end

   vcp_pwm u_pwm (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .duty    (drive_duty),
      .pwm     (valve_driver_channel)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_loop_tick;
      closed_loop_select && tick_r;
   endsequence
   sequence s_script_hold;
      !closed_loop_select [*2];
   endsequence

   a_closed_duty_src: assert property (s_loop_tick |=> drive_duty == $past(sat15(pi_sum)))
      else $error("closed loop duty not taken from regulator");
   a_open_duty_src: assert property (s_script_hold |-> drive_duty == $past(script_duty_r))
      else $error("open loop duty differs from script duty");
   a_lower_throttle: assert property (lower_source_select && tick_r
      |-> span_prod == span * throttle_pos)
      else $error("lowering command not from throttle");
   a_lower_script: assert property (!lower_source_select && tick_r
      |-> span_prod == span * script_lower_command_r)
      else $error("lowering command not from script value");
   a_sp_ceiling: assert property (base_sp <= coil_current_ceiling_r
      && coil_current_ceiling_r <= vcp_pkg::CUR_RAW_MAX)
      else $error("setpoint above ceiling");
   a_sp_floor: assert property (coil_current_floor_r <= coil_current_ceiling_r
      |-> base_sp >= coil_current_floor_r)
      else $error("setpoint below floor");
   a_sp_mapping: assert property (lower_cmd == 15'h0000 |-> base_sp == floor_eff)
      else $error("zero command not mapped to floor");
   a_err_sample: assert property (s_loop_tick |=> sp_r == $past(sp_dith))
      else $error("setpoint not sampled on tick");
   a_no_windup: assert property (s_loop_tick ##0 (sat_hi && err > 0)
      |=> $stable(integ_r))
      else $error("integrator grew while output clamped");
   a_no_windup_low: assert property (s_loop_tick ##0 (sat_lo && err < 0)
      |=> $stable(integ_r))
      else $error("integrator fell while output clamped low");
   a_open_idle: assert property (!closed_loop_select |=> integ_r == 0 && sp_r == 0)
      else $error("regulator state active in open loop");
endmodule : vcp_top
`default_nettype wire

// ===== inc/vcp_pkg.sv
// constants and types shared by the valve current pwm control block
package vcp_pkg;
   localparam int CLK_PERIOD_NS       = 10;
   localparam int TICK_PERIOD_US      = 1000;
   localparam int TICK_CYC            = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int DITHER_MS_PER_CODE  = 16;
   localparam int DITHER_HALF_TICKS   = DITHER_MS_PER_CODE * 1000 / TICK_PERIOD_US / 2;
   localparam int PCT_SHIFT           = 15;
   localparam int KP_SHIFT            = 8;
   localparam int KI_SHIFT            = 12;
   localparam int PWM_CNT_W           = 10;
   localparam logic [9:0]  CUR_RAW_MAX   = 10'h25F;
   localparam logic [14:0] DUTY_MAX      = 15'h7FFF;
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_CEIL      = 12'h004;
   localparam logic [11:0] OFS_FLOOR     = 12'h008;
   localparam logic [11:0] OFS_DPCT      = 12'h00C;
   localparam logic [11:0] OFS_DPER      = 12'h010;
   localparam logic [11:0] OFS_KP        = 12'h014;
   localparam logic [11:0] OFS_KI        = 12'h018;
   localparam logic [11:0] OFS_SDUTY     = 12'h01C;
   localparam logic [11:0] OFS_SLOWER    = 12'h020;
   localparam logic [11:0] OFS_STDUTY    = 12'h024;
   localparam logic [11:0] OFS_STSP      = 12'h028;
   localparam int CTRL_CL_BIT  = 0;
   localparam int CTRL_LS_BIT  = 1;
   localparam logic [1:0]  CTRL_RST      = 2'h0;
   localparam logic [9:0]  CEIL_RST      = 10'h000;
   localparam logic [9:0]  FLOOR_RST     = 10'h000;
   localparam logic [14:0] DPCT_RST      = 15'h0000;
   localparam logic [2:0]  DPER_RST      = 3'h1;
   localparam logic [13:0] KP_RST        = 14'h0052;
   localparam logic [14:0] KI_RST        = 15'h0147;
   typedef logic [14:0] vcp_duty_t;
endpackage : vcp_pkg

// ===== hdl/vcp_dither.sv
// square add/subtract dither offset generator on the control tick
`timescale 1ns/10ps
`default_nettype none
module vcp_dither (
   input  wire logic               clk_sys,   // system clock
   input  wire logic               rstn,      // async reset, active low
   input  wire logic               tick,      // control tick enable
   input  wire logic               run,       // closed loop active
   input  wire logic [2:0]         code,      // dither period code
   input  wire logic [9:0]         ceil,      // ceiling current
   input  wire logic [14:0]        pct,       // dither amplitude fraction
   output logic signed [11:0]      offset     // signed setpoint offset
);
   logic [5:0]  half_last;
   logic [5:0]  cnt_r;
   logic        phase_r;
   logic [24:0] prod;
   logic [9:0]  amp;

   // code 0 is outside the documented range; treat it as the shortest period
   always_comb begin
      half_last = 6'((code == 3'h0 ? 3'h1 : code) * vcp_pkg::DITHER_HALF_TICKS - 1);
      prod      = ceil * pct;
      amp       = prod[24:vcp_pkg::PCT_SHIFT];
      offset    = phase_r ? -$signed({2'b00, amp}) : $signed({2'b00, amp});
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r   <= '0;
         phase_r <= 1'b0;
      end else if (!run) begin
         cnt_r   <= '0;
         phase_r <= 1'b0;
      end else if (tick) begin
         if (cnt_r >= half_last) begin
            cnt_r   <= '0;
            phase_r <= ~phase_r;
         end else begin
            cnt_r <= cnt_r + 6'h01;
         end
      end
   end

   a_dither_half_flip: assert property (@(posedge clk_sys) disable iff (!rstn)
      run && tick && cnt_r >= half_last |=> phase_r != $past(phase_r))
      else $error("dither phase did not flip at half period");
endmodule : vcp_dither
`default_nettype wire

// ===== hdl/vcp_pwm.sv
// pwm pin generator from a 15-bit duty
`timescale 1ns/10ps
`default_nettype none
module vcp_pwm (
   input  wire logic               clk_sys,   // system clock
   input  wire logic               rstn,      // async reset, active low
   input  wire logic [14:0]        duty,      // duty 0 to full scale
   output logic                    pwm        // registered pwm level
);
   logic [vcp_pkg::PWM_CNT_W-1:0] cnt_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
         pwm   <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 10'h001;
         // full scale duty keeps the pin high without a single low cycle
         pwm   <= (duty == vcp_pkg::DUTY_MAX) || (cnt_r < duty[14:15-vcp_pkg::PWM_CNT_W]);
      end
   end
endmodule : vcp_pwm
`default_nettype wire

// ===== testbench/vcp_coil_model.sv
// behavioural valve coil: current follows the averaged driver pwm
`timescale 1ns/10ps
`default_nettype none
module vcp_coil_model (
   input  wire logic       clk_sys,      // system clock
   input  wire logic       rstn,         // async reset, active low
   input  wire logic       pwm,          // driver pwm pin
   input  wire logic       fix_en,       // hold current at fix_val
   input  wire logic [9:0] fix_val,      // held current, raw
   output logic      [9:0] coil_current  // measured current, raw
);
   logic [9:0]  ph_r;
   logic [10:0] hi_r;
   logic [9:0]  avg_r;
   // current lags one pwm window, as an inductive coil would
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ph_r  <= 10'h000;
         hi_r  <= 11'h000;
         avg_r <= 10'h000;
      end else begin
         ph_r <= ph_r + 10'h001;
         if (ph_r == 10'h3FF) begin
            avg_r <= 10'((22'(hi_r) * 22'h00_025F) >> 10);
            hi_r  <= {10'h000, pwm};
         end else begin
            hi_r <= hi_r + {10'h000, pwm};
         end
      end
   end
   assign coil_current = fix_en ? fix_val : avg_r;
endmodule : vcp_coil_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the valve current pwm control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int TICK = 20;
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, pin, fix_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [14:0] throttle_pos, drive_duty;
   logic [9:0]  coil_current, fix_val;
   int          failures, num_checks;
   vcp_top #(.TICK_CYC(TICK)) u_vcp_top (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .throttle_pos(throttle_pos),
      .coil_current(coil_current), .valve_driver_channel(pin), .drive_duty(drive_duty));
   vcp_coil_model u_vcp_coil_model (.clk_sys(clk_sys), .rstn(rstn), .pwm(pin),
      .fix_en(fix_en), .fix_val(fix_val), .coil_current(coil_current));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic wrap_up();
      if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic clks(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : clks
   // request held until pready is sampled high, then released
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(a, 1'b1, d, r, e);
   endtask : wr
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      xfer(a, 1'b0, 32'h0000_0000, r, e);
      chk(nm, exp, r);
   endtask : rd_chk
   task automatic t_regs();
      logic [11:0] ofs [9] = '{vcp_pkg::OFS_CTRL, vcp_pkg::OFS_CEIL, vcp_pkg::OFS_FLOOR,
         vcp_pkg::OFS_DPCT, vcp_pkg::OFS_DPER, vcp_pkg::OFS_KP, vcp_pkg::OFS_KI,
         vcp_pkg::OFS_STDUTY, vcp_pkg::OFS_STSP};
      logic [31:0] rv [9] = '{32'(vcp_pkg::CTRL_RST), 32'(vcp_pkg::CEIL_RST),
         32'(vcp_pkg::FLOOR_RST), 32'(vcp_pkg::DPCT_RST), 32'(vcp_pkg::DPER_RST),
         32'(vcp_pkg::KP_RST), 32'(vcp_pkg::KI_RST), 32'h0000_0000, 32'h0000_0000};
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < 9; i++) rd_chk("reset_value", ofs[i], rv[i]);
      xfer(12'h02C, 1'b0, 32'h0000_0000, r, e);
      chk("unmapped_err", 32'h0000_0001, 32'(e));
      xfer(vcp_pkg::OFS_STDUTY, 1'b1, 32'h0000_1234, r, e);
      chk("ro_write_err", 32'h0000_0000, 32'(e));
      rd_chk("ro_unchanged", vcp_pkg::OFS_STDUTY, 32'h0000_0000);
   endtask : t_regs
   task automatic t_open();
      logic [14:0] dv [4] = '{15'h0000, 15'h4000, 15'h0020, 15'h7FFF};
      int          hi;
      for (int i = 0; i < 4; i++) begin
         wr(vcp_pkg::OFS_SDUTY, 32'(dv[i]));
         clks(2);
         chk("open_duty", 32'(dv[i]), 32'(drive_duty));
         clks(1100);
         hi = 0;
         repeat (1024) begin
            @(posedge clk_sys);
            hi += int'(pin === 1'b1);
         end
         chk("pin_high", (dv[i] == 15'h7FFF) ? 32'h0000_0400 : 32'(dv[i][14:5]), 32'(hi));
      end
      rd_chk("open_setpoint", vcp_pkg::OFS_STSP, 32'h0000_0000);
   endtask : t_open
   task automatic t_prop();
      wr(vcp_pkg::OFS_CEIL, 32'h0000_03FF);
      rd_chk("ceil_sat", vcp_pkg::OFS_CEIL, 32'h0000_025F);
      wr(vcp_pkg::OFS_CEIL, 32'h0000_0258);
      wr(vcp_pkg::OFS_FLOOR, 32'h0000_0064);
      wr(vcp_pkg::OFS_KP, 32'h0000_0100);
      wr(vcp_pkg::OFS_KI, 32'h0000_0000);
      wr(vcp_pkg::OFS_SLOWER, 32'h0000_4000);
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0001);
      clks(3 * TICK);
      chk("prop_duty", 32'h0000_015E, 32'(drive_duty));
      rd_chk("mid_setpoint", vcp_pkg::OFS_STSP, 32'h0000_015E);
      fix_val <= 10'h064;
      clks(2 * TICK);
      chk("err_duty", 32'h0000_00FA, 32'(drive_duty));
      fix_val <= 10'h000;
      throttle_pos <= 15'h7FFF;
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0003);
      clks(3 * TICK);
      chk("throttle_duty", 32'h0000_0257, 32'(drive_duty));
      wr(vcp_pkg::OFS_SLOWER, 32'h0000_0000);
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0001);
      clks(3 * TICK);
      chk("floor_duty", 32'h0000_0064, 32'(drive_duty));
      wr(vcp_pkg::OFS_FLOOR, 32'h0000_03FF);
      clks(3 * TICK);
      chk("floor_over_ceil", 32'h0000_0258, 32'(drive_duty));
      wr(vcp_pkg::OFS_FLOOR, 32'h0000_0064);
   endtask : t_prop
   task automatic t_integ();
      logic [14:0] d1;
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0000);
      wr(vcp_pkg::OFS_SDUTY, 32'h0000_1234);
      wr(vcp_pkg::OFS_KP, 32'h0000_0052);
      wr(vcp_pkg::OFS_KI, 32'h0000_7FFF);
      wr(vcp_pkg::OFS_SLOWER, 32'h0000_4000);
      fix_val <= 10'h25F;
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0001);
      clks(3 * TICK);
      chk("duty_low_clamp", 32'h0000_0000, 32'(drive_duty));
      fix_val <= 10'h000;
      clks(TICK + 2);
      d1 = drive_duty;
      chk("no_windup_low", 32'h0000_0001, 32'(d1 != 15'h0000));
      clks(TICK);
      chk("duty_rise", 32'h0000_0001, 32'(drive_duty > d1));
      clks(20 * TICK);
      chk("duty_high_clamp", 32'h0000_7FFF, 32'(drive_duty));
      fix_val <= 10'h25F;
      clks(2 * TICK + 2);
      chk("no_windup", 32'h0000_0001, 32'(drive_duty < 15'h7FFF));
   endtask : t_integ
   task automatic t_dither(input int code);
      logic [31:0] v, v0, r;
      logic        e;
      int          t [2];
      wr(vcp_pkg::OFS_KI, 32'h0000_0000);
      wr(vcp_pkg::OFS_DPER, 32'(code));
      wr(vcp_pkg::OFS_DPCT, 32'h0000_4000);
      clks(2 * TICK);
      xfer(vcp_pkg::OFS_STSP, 1'b0, 32'h0000_0000, v0, e);
      for (int k = 0; k < 2; k++) begin
         t[k] = 0;
         v = v0;
         while (v === v0 && t[k] < 3000) begin
            xfer(vcp_pkg::OFS_STSP, 1'b0, 32'h0000_0000, v, e);
            t[k] += 4;
         end
         chk("dither_level", 32'h0000_0001, 32'(v == 32'h0000_028A || v == 32'h0000_0032));
         v0 = v;
      end
      // code 0 lies outside the legal range and runs as code 1
      r = 32'(t[1] - 8 * ((code == 0) ? 1 : code) * TICK);
      chk("dither_half", 32'h0000_0001, 32'($signed(r) >= -6 && $signed(r) <= 6));
   endtask : t_dither
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; throttle_pos = 15'h0000; fix_en = 1'b1; fix_val = 10'h000;
      failures = 0;
      num_checks = 0;
      clks(8);
      rstn <= 1'b1;
      t_regs();
      t_open();
      t_prop();
      t_integ();
      t_dither(1);
      t_dither(7);
      t_dither(0);
      wr(vcp_pkg::OFS_CTRL, 32'h0000_0000);
      clks(2 * TICK);
      rd_chk("open_sp_zero", vcp_pkg::OFS_STSP, 32'h0000_0000);
      fix_en <= 1'b0;
      wr(vcp_pkg::OFS_SDUTY, 32'h0000_4000);
      clks(2100);
      chk("coil_follows", 32'h0000_012F, 32'(coil_current));
      wrap_up();
   end
   // run needs roughly 15k cycles, limit leaves ample margin
   initial begin
      #1_000_000;
      failures++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
